/* File: src/rstgen_top.sv */
// Reset generator with AXI4-Lite control registers
// What this block does
// R1: Four reset sources: pin, address trap, watchdog, bad clock setup; last three malfunction.
// R2: Malfunction reset lasts at most 24 oscillator periods, reset pin driven low.
// R3: Malfunction pulse logic is not initialised, may pulse once at power-up.
// R4: Reset loads PC vector FFFEH and enables watchdog; watchdog and system controls take defaults, area bases keep their value.
// R5: Reset clears master interrupt enable and all interrupt request latches.
// R6: Reset clears every individual interrupt enable flag.
// R7: Reset clears the timing generator prescaler and divider.
// R8: Pin held low at least 12 oscillator periods applies reset.
// R9: Pin going high releases reset; execution starts at vector FFFEH.
// R10: Fetch from register area traps; RAM fetch traps when RAM select set.
// R11: Trap response selectable reset or interrupt; trapped area selectable.
// R12: Trap action select reads 1 after reset, selecting reset.
// R13: Watchdog action select reads 1 after reset, selecting reset.
// R14: Clock reset on both enables cleared, or selected oscillator's enable cleared.
// R15: Offending write does not stop oscillators during clock reset.
// R16: Clock select 1 picks low-frequency oscillator, 0 high-frequency.
// R17: Clearing high-frequency enable stops the high-frequency oscillator.
// R18: Internal reset combines pin low and any malfunction pulse.
`timescale 1ns/1ps
module rstgen_top
    import rstgen_pkg::*;
#(
    parameter int PIN_LOW_CYC = PIN_MIN_LOW_CYC,
    parameter int MALF_CYC    = MALF_PULSE_CYC
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Reset pin, open drain
    input  wire logic        resetPinIn,
    output logic             resetPinOut,
    output logic             resetPinOe,
    // Core side
    input  rstgen_fetch_t    fetch,
    input  wire logic        watchdogExpired,
    output logic             coreResetn,
    output logic [15:0]      resetVector,
    output logic             trapInterrupt,
    output logic             watchdogInterrupt,
    output logic             watchdogEnable,
    output logic             highOscEnable,
    output logic             lowOscEnable,
    output logic             clockSelLow,
    output logic [15:0]      prescaler
);
    if (PIN_LOW_CYC < 1 || PIN_LOW_CYC > 255) begin
        $error("PIN_LOW_CYC out of range");
    end

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    logic [3:0]  watchdogCtrl;
    logic [2:0]  sysCtrl;
    logic [15:0] sfrBase;
    logic [15:0] ramBase;
    logic        trapHit;
    logic        trapReset;
    logic        wdogReset;
    logic        clkReset;
    logic        malfTrigger;
    logic        malfActive;
    logic        clkWrite;
    logic [2:0]  clkWdata;

    function automatic logic inArea(input logic [15:0] a, input logic [15:0] base);
        inArea = (a[15:8] == base[15:8]);
    endfunction

    assign trapHit = fetch.valid && (inArea(fetch.addr, sfrBase)
        || (watchdogCtrl[WDC_TRAP_RAM_BIT] && inArea(fetch.addr, ramBase))); // R10
    assign trapReset = trapHit && watchdogCtrl[WDC_TRAP_ACT_BIT]; // R11
    assign wdogReset = watchdogExpired && watchdogCtrl[WDC_WDOG_ACT_BIT];
    // Illegal oscillator shutdown
    assign clkReset = clkWrite && (
        (!clkWdata[SYS_HIGH_EN_BIT] && !clkWdata[SYS_LOW_EN_BIT]
            && sysCtrl[SYS_HIGH_EN_BIT] && sysCtrl[SYS_LOW_EN_BIT])
        || (!clkWdata[SYS_HIGH_EN_BIT] && !sysCtrl[SYS_CLKSEL_BIT])
        || (!clkWdata[SYS_LOW_EN_BIT] && sysCtrl[SYS_CLKSEL_BIT])); // R14
    assign malfTrigger = trapReset || wdogReset || clkReset; // R1

    rstgen_pulse #(
        .PULSE_CYC (MALF_CYC)
    ) u_pulse (
        .clk     (clk),
        .trigger (malfTrigger),
        .active  (malfActive)
    );

    // Pin low filter
    logic [7:0] lowCount;
    logic [7:0] next_lowCount;
    logic       pinReset;
    logic       next_pinReset;

    always_comb begin
        next_lowCount = lowCount;
        next_pinReset = pinReset;
        if (resetPinIn || resetPinOe) begin
            next_lowCount = 8'h00;
            next_pinReset = 1'b0; // R9
        // Reset on the last sample of the minimum low time
        end else if (lowCount < 8'(PIN_LOW_CYC - 1)) begin
            next_lowCount = lowCount + 8'h01;
        end else begin
            next_pinReset = 1'b1; // R8
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lowCount <= 8'h00;
            pinReset <= 1'b1;
        end else begin
            lowCount <= next_lowCount;
            pinReset <= next_pinReset;
        end
    end

    logic sysReset;
    assign sysReset    = pinReset || malfActive; // R18
    assign resetPinOut = 1'b0;
    assign resetPinOe  = malfActive; // R2
    assign coreResetn  = !sysReset;
    assign resetVector = RESET_VECTOR_ADDR; // R4

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] irqEnable;
    logic [15:0] irqLatch;
    logic [15:0] next_irqEnable;
    logic [15:0] next_irqLatch;
    logic [3:0]  next_watchdogCtrl;
    logic [2:0]  next_sysCtrl;
    logic [15:0] next_sfrBase;
    logic [15:0] next_ramBase;
    logic [15:0] next_prescaler;
    logic        wrFire;
    logic [7:0]  wrAddr;
    logic [31:0] wrData;
    logic        wrStrb;

    assign clkWrite = wrFire && (wrAddr == ADDR_SYSTEM_CTRL) && wrStrb;
    assign clkWdata = wrData[2:0];

    always_comb begin
        next_irqEnable    = irqEnable;
        next_irqLatch     = irqLatch;
        next_watchdogCtrl = watchdogCtrl;
        next_sysCtrl      = sysCtrl;
        next_sfrBase      = sfrBase;
        next_ramBase      = ramBase;
        next_prescaler    = prescaler + 16'h0001;
        if (wrFire) begin
            case (wrAddr)
                ADDR_WATCHDOG_CTRL: if (wrStrb) next_watchdogCtrl = wrData[3:0];
                ADDR_SYSTEM_CTRL: begin
                    if (wrStrb && !clkReset) begin
                        next_sysCtrl = wrData[2:0]; // R16 R17
                    end
                end
                ADDR_IRQ_ENABLE: next_irqEnable = wrData[15:0];
                ADDR_IRQ_LATCH:  next_irqLatch  = irqLatch & wrData[15:0];
                ADDR_SFR_AREA:   next_sfrBase   = wrData[15:0];
                ADDR_RAM_AREA:   next_ramBase   = wrData[15:0];
                default: ;
            endcase
        end
        // Set wins over clear
        if (trapHit && !watchdogCtrl[WDC_TRAP_ACT_BIT]) begin
            next_irqLatch[IRQ_TRAP_BIT] = 1'b1;
        end
        if (watchdogExpired && !watchdogCtrl[WDC_WDOG_ACT_BIT]) begin
            next_irqLatch[IRQ_WDOG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqEnable    <= IRQ_ENABLE_RESET;
            irqLatch     <= IRQ_LATCH_RESET;
            watchdogCtrl <= WDC_RESET;
            sysCtrl      <= SYS_RESET;
            sfrBase      <= 16'h0000;
            ramBase      <= 16'h0100;
            prescaler    <= 16'h0000;
        end else if (sysReset) begin
            irqEnable    <= IRQ_ENABLE_RESET; // R5 R6
            irqLatch     <= IRQ_LATCH_RESET; // R5
            watchdogCtrl <= WDC_RESET; // R4 R12 R13
            sysCtrl      <= SYS_RESET;
            prescaler    <= 16'h0000; // R7
        end else begin
            irqEnable    <= next_irqEnable;
            irqLatch     <= next_irqLatch;
            watchdogCtrl <= next_watchdogCtrl;
            sysCtrl      <= next_sysCtrl; // R15
            sfrBase      <= next_sfrBase;
            ramBase      <= next_ramBase;
            prescaler    <= next_prescaler;
        end
    end

    assign trapInterrupt     = irqLatch[IRQ_TRAP_BIT];
    assign watchdogInterrupt = irqLatch[IRQ_WDOG_BIT];
    assign watchdogEnable    = watchdogCtrl[WDC_WDOG_EN_BIT];
    assign highOscEnable     = sysCtrl[SYS_HIGH_EN_BIT];
    assign lowOscEnable      = sysCtrl[SYS_LOW_EN_BIT];
    assign clockSelLow       = sysCtrl[SYS_CLKSEL_BIT];

    // ------------------------------------------------------------
    // AXI4-Lite write
    // ------------------------------------------------------------
    logic awHeld;
    logic wHeld;
    logic next_awHeld;
    logic next_wHeld;
    logic next_bvalid;
    logic [7:0]  awAddr;
    logic [31:0] wDataReg;
    logic [7:0]  next_awAddr;
    logic [31:0] next_wDataReg;
    logic        wStrbHeld;
    logic        next_wStrbHeld;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign wrAddr = awHeld ? awAddr : s_axi_awaddr;
    assign wrData = wHeld ? wDataReg : s_axi_wdata;
    assign wrStrb = wHeld ? wStrbHeld : s_axi_wstrb[0];
    assign wrFire = (awHeld || (s_axi_awvalid && s_axi_awready))
        && (wHeld || (s_axi_wvalid && s_axi_wready));

    always_comb begin
        next_awHeld   = awHeld;
        next_wHeld    = wHeld;
        next_awAddr   = awAddr;
        next_wDataReg = wDataReg;
        next_wStrbHeld = wStrbHeld;
        next_bvalid   = s_axi_bvalid && !s_axi_bready;
        if (wrFire) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                next_awHeld = 1'b1;
                next_awAddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                next_wHeld    = 1'b1;
                next_wDataReg = s_axi_wdata;
                next_wStrbHeld = s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 8'h00;
            wDataReg     <= 32'h00000000;
            wStrbHeld    <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end else begin
            awHeld       <= next_awHeld;
            wHeld        <= next_wHeld;
            awAddr       <= next_awAddr;
            wDataReg     <= next_wDataReg;
            wStrbHeld    <= next_wStrbHeld;
            s_axi_bvalid <= next_bvalid;
        end
    end
    assign s_axi_bresp = RESP_OKAY;

    // ------------------------------------------------------------
    // AXI4-Lite read
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    logic        next_rvalid;

    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = RESP_OKAY;

    always_comb begin
        next_rdata  = s_axi_rdata;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            case (s_axi_araddr)
                ADDR_WATCHDOG_CTRL: next_rdata = {28'h0000000, watchdogCtrl};
                ADDR_SYSTEM_CTRL:   next_rdata = {29'h00000000, sysCtrl};
                ADDR_IRQ_ENABLE:    next_rdata = {16'h0000, irqEnable};
                ADDR_IRQ_LATCH:     next_rdata = {16'h0000, irqLatch};
                ADDR_STATUS:        next_rdata = {30'h00000000, malfActive, pinReset};
                ADDR_SFR_AREA:      next_rdata = {16'h0000, sfrBase};
                ADDR_RAM_AREA:      next_rdata = {16'h0000, ramBase};
                default:            next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rdata  <= 32'h00000000;
            s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_rdata  <= next_rdata;
            s_axi_rvalid <= next_rvalid;
        end
    end
endmodule

/* File: src/rstgen_pkg.sv */
// Package of constants and types for the reset generator
package rstgen_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int OSC_CLOCK_FREQ_HZ   = 125000000;
    localparam int MALF_PULSE_OSC      = 24;   // Longest malfunction reset, osc periods
    localparam int PIN_MIN_LOW_OSC     = 12;   // Least external low time, osc periods
    localparam int MALF_PULSE_CYC      = MALF_PULSE_OSC;
    localparam int PIN_MIN_LOW_CYC     = PIN_MIN_LOW_OSC;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_WATCHDOG_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SYSTEM_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_LATCH     = 8'h0C;
    localparam logic [7:0] ADDR_STATUS        = 8'h10;
    localparam logic [7:0] ADDR_SFR_AREA      = 8'h14;
    localparam logic [7:0] ADDR_RAM_AREA      = 8'h18;

    // watchdog_control_one fields
    localparam int WDC_TRAP_RAM_BIT   = 0;
    localparam int WDC_TRAP_ACT_BIT   = 1;
    localparam int WDC_WDOG_ACT_BIT   = 2;
    localparam int WDC_WDOG_EN_BIT    = 3;
    localparam logic [3:0] WDC_RESET  = 4'hE;

    // system_control_two fields
    localparam int SYS_CLKSEL_BIT     = 0;
    localparam int SYS_LOW_EN_BIT     = 1;
    localparam int SYS_HIGH_EN_BIT    = 2;
    localparam logic [2:0] SYS_RESET  = 3'h4;

    localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0000;
    localparam logic [15:0] IRQ_LATCH_RESET  = 16'h0000;
    localparam int IRQ_TRAP_BIT = 2;
    localparam int IRQ_WDOG_BIT = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } rstgen_fetch_t;

    typedef enum logic [1:0] {
        RG_IDLE,
        RG_MALF,
        RG_PIN
    } rstgen_state_t;

endpackage

/* File: src/rstgen_pulse.sv */
// Malfunction reset pulse stretcher
`timescale 1ns/1ps
module rstgen_pulse
    import rstgen_pkg::*;
#(
    parameter int PULSE_CYC = MALF_PULSE_CYC
) (
    input  wire logic clk,
    input  wire logic trigger,
    output logic      active
);
    if (PULSE_CYC < 1 || PULSE_CYC > 255) begin
        $error("PULSE_CYC out of range");
    end

    // No reset: power-up state models one full pulse
    logic [7:0] count = 8'(PULSE_CYC);
    logic [7:0] next_count;

    always_comb begin
        next_count = count;
        if (trigger) begin
            next_count = 8'(PULSE_CYC);
        end else if (count != 8'h00) begin
            next_count = count - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        count <= next_count; // R3
    end

    assign active = (count != 8'h00); // R2
endmodule

/* File: testbench/rstgen_monitor.sv */
// Port checker for the reset generator
`timescale 1ns/1ps
module rstgen_monitor
    import rstgen_pkg::*;
#(
    parameter int PIN_LOW_CYC = PIN_MIN_LOW_CYC,
    parameter int MALF_CYC    = MALF_PULSE_CYC
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        resetPinIn,
    input wire logic        resetPinOut,
    input wire logic        resetPinOe,
    input rstgen_fetch_t    fetch,
    input wire logic        watchdogExpired,
    input wire logic        coreResetn,
    input wire logic [15:0] resetVector,
    input wire logic        trapInterrupt,
    input wire logic        watchdogInterrupt,
    input wire logic        watchdogEnable,
    input wire logic        highOscEnable,
    input wire logic        lowOscEnable,
    input wire logic        clockSelLow,
    input wire logic [15:0] prescaler
);
    logic [7:0] oeRun = 8'h00;
    logic [7:0] lowRun = 8'h00;
    logic [7:0] next_oeRun;
    logic [7:0] next_lowRun;

    // ------------------------------------------------------------
    // Run lengths of own pulse and external low
    // ------------------------------------------------------------
    always_comb begin
        next_oeRun  = resetPinOe ? oeRun + 8'h01 : 8'h00;
        next_lowRun = (resetPinIn || resetPinOe) ? 8'h00 : lowRun + {7'h00, lowRun != 8'hFF};
    end
    always_ff @(posedge clk) begin
        oeRun  <= next_oeRun;
        lowRun <= next_lowRun;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_pinOut;
        resetPinOe |-> !resetPinOut && !coreResetn;
    endproperty
    a_pinOut: assert property (p_pinOut) else $error("pin pulse without low level");
    property p_oeLen;
        oeRun <= 8'(MALF_CYC);
    endproperty
    a_oeLen: assert property (p_oeLen) else $error("pulse too long");
    property p_trap;
        fetch.valid && fetch.addr[15:8] == 8'h00 && coreResetn
            |-> ##[1:2] (resetPinOe || trapInterrupt);
    endproperty
    a_trap: assert property (p_trap) else $error("fetch in register area missed");
    property p_wdog;
        watchdogExpired && coreResetn |-> ##[1:2] (resetPinOe || watchdogInterrupt);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog expiry missed");
    property p_vector;
        resetVector == RESET_VECTOR_ADDR;
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");
    property p_pinFilt;
        lowRun >= 8'(PIN_LOW_CYC) |-> !coreResetn;
    endproperty
    a_pinFilt: assert property (p_pinFilt) else $error("pin low ignored");
    property p_release;
        $rose(coreResetn) |-> resetPinIn && !resetPinOe;
    endproperty
    a_release: assert property (p_release) else $error("early release");
    property p_clr;
        !coreResetn [*2] |-> prescaler == 16'h0000 && !trapInterrupt && !watchdogInterrupt
            && watchdogEnable;
    endproperty
    a_clr: assert property (p_clr) else $error("state not cleared");
    property p_osc;
        clockSelLow ? lowOscEnable : highOscEnable;
    endproperty
    a_osc: assert property (p_osc) else $error("selected oscillator stopped");
endmodule

bind rstgen_top rstgen_monitor #(.PIN_LOW_CYC(PIN_LOW_CYC), .MALF_CYC(MALF_CYC)) rstgen_monitor_i (
    .clk(clk), .resetn(resetn), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .fetch(fetch), .watchdogExpired(watchdogExpired),
    .coreResetn(coreResetn), .resetVector(resetVector), .trapInterrupt(trapInterrupt),
    .watchdogInterrupt(watchdogInterrupt), .watchdogEnable(watchdogEnable),
    .highOscEnable(highOscEnable), .lowOscEnable(lowOscEnable), .clockSelLow(clockSelLow),
    .prescaler(prescaler));

/* File: testbench/rstgen_board.sv */
// Board reset circuit on the open-drain reset pin
`timescale 1ns/1ps
module rstgen_board (
    input  wire logic pressLow,
    input  wire logic resetPinOut,
    input  wire logic resetPinOe,
    output logic      pinLevel
);
    // Pull-up unless either party pulls low
    assign pinLevel = !(pressLow || (resetPinOe && !resetPinOut));
endmodule

/* File: testbench/rstgen_top_tb.sv */
// Self-checking bench for the reset generator
`timescale 1ns/1ps
module rstgen_top_tb
    import rstgen_pkg::*;
;
    localparam logic [31:0] DEFS [8] = '{32'hE, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h0};
    localparam logic [2:0]  CLKW [8] = '{3'h7, 3'h3, 3'h7, 3'h5, 3'h7, 3'h1, 3'h6, 3'h2};
    localparam logic        CLKR [8] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
    localparam int          PRESS [2] = '{11, 16};
    logic          clk = 1'h0, resetn = 1'h0, pressLow = 1'h0, wdogExp = 1'h0;
    logic          awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
    logic [7:0]    awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0]   wData = 32'h0, rd, rData;
    rstgen_fetch_t fetchIn = '0;
    logic          awReady, wReady, bValid, arReady, rValid, pinLevel, pinOut, pinOe, coreResetn;
    logic          trapIrq, wdogIrq, wdogEn, highEn, lowEn, selLow;
    logic [1:0]    bResp, rResp;
    logic [15:0]   resetVector, prescaler;
    int            mismatches = 0, checks_done = 0, cycles = 0, oeCount = 0;

    always #4 clk = ~clk;
    always @(negedge clk) if (pinOe === 1'h1) oeCount++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            give_verdict();
        end
    end

    rstgen_top rstgen_top_i (.clk(clk), .resetn(resetn), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .resetPinIn(pinLevel), .resetPinOut(pinOut), .resetPinOe(pinOe),
        .fetch(fetchIn), .watchdogExpired(wdogExp), .coreResetn(coreResetn),
        .resetVector(resetVector), .trapInterrupt(trapIrq), .watchdogInterrupt(wdogIrq),
        .watchdogEnable(wdogEn), .highOscEnable(highEn), .lowOscEnable(lowEn),
        .clockSelLow(selLow), .prescaler(prescaler));
    rstgen_board rstgen_board_i (.pressLow(pressLow), .resetPinOut(pinOut), .resetPinOe(pinOe),
        .pinLevel(pinLevel));

    task automatic checkVal(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        logic doneA, doneW;
        @(posedge clk);
        {awAddr, wData, awValid, wValid, bReady} <= {a, d, 3'h7};
        {doneA, doneW} = 2'h0;
        while (!(doneA && doneW)) begin
            @(negedge clk);
            {doneA, doneW} = {doneA || awReady, doneW || wReady};
            @(posedge clk);
            if (doneA) awValid <= 1'h0;
            if (doneW) wValid <= 1'h0;
        end
        do begin
            @(negedge clk);
            doneA = bValid;
            @(posedge clk);
        end while (doneA !== 1'h1);
        bReady <= 1'h0;
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d);
        logic done;
        @(posedge clk);
        {arAddr, arValid, rReady} <= {a, 2'h3};
        do begin
            @(negedge clk);
            done = arReady;
            @(posedge clk);
        end while (done !== 1'h1);
        arValid <= 1'h0;
        do begin
            @(negedge clk);
            {done, d} = {rValid, rData};
            @(posedge clk);
        end while (done !== 1'h1);
        rReady <= 1'h0;
    endtask
    task automatic strobe(input logic isFetch, input logic [15:0] a);
        @(posedge clk);
        {wdogExp, fetchIn} <= {!isFetch, isFetch, a};
        @(posedge clk);
        {wdogExp, fetchIn} <= {2'h0, a};
    endtask
    task automatic expectPulse(input int e);
        repeat (30) @(posedge clk);
        checkVal(32'(oeCount), 32'(e), "pulse length");
        oeCount = 0;
    endtask
    task give_verdict();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        repeat (30) @(posedge clk);
        checkVal({31'h0, oeCount <= MALF_PULSE_CYC}, 32'h1, "power-up pulse");
        oeCount = 0;
        checkVal({16'h0, resetVector}, {16'h0, RESET_VECTOR_ADDR}, "vector");
        checkVal({31'h0, wdogEn}, 32'h1, "watchdog enabled");
        foreach (DEFS[i]) begin
            axiRead(8'(4 * i), rd);
            checkVal(rd, DEFS[i], "reset value");
        end
        axiWrite(ADDR_IRQ_ENABLE, 32'hFFFF);
        strobe(1'h0, 16'h8000);
        expectPulse(MALF_PULSE_CYC);
        axiRead(ADDR_IRQ_ENABLE, rd);
        checkVal(rd, 32'h0, "enables after reset");
        strobe(1'h1, 16'h0010);
        expectPulse(MALF_PULSE_CYC);
        axiWrite(ADDR_WATCHDOG_CTRL, 32'h8);
        strobe(1'h0, 16'h8000);
        strobe(1'h1, 16'h0120);
        expectPulse(0);
        checkVal({30'h0, trapIrq, wdogIrq}, 32'h1, "interrupt mode");
        axiWrite(ADDR_WATCHDOG_CTRL, 32'h9);
        strobe(1'h1, 16'h0120);
        expectPulse(0);
        checkVal({30'h0, trapIrq, wdogIrq}, 32'h3, "ram trap");
        axiWrite(ADDR_IRQ_LATCH, 32'h0);
        @(negedge clk);
        checkVal({30'h0, trapIrq, wdogIrq}, 32'h0, "latch clear");
        foreach (PRESS[i]) begin
            @(posedge clk);
            pressLow <= 1'h1;
            repeat (PRESS[i]) @(posedge clk);
            @(negedge clk);
            checkVal({31'h0, coreResetn}, {31'h0, PRESS[i] < PIN_MIN_LOW_CYC}, "pin filter");
            if (PRESS[i] > PIN_MIN_LOW_CYC)
                checkVal({16'h0, prescaler}, 32'h0, "prescaler");
            @(posedge clk);
            pressLow <= 1'h0;
            repeat (4) @(negedge clk);
            checkVal({31'h0, coreResetn}, 32'h1, "pin release");
        end
        axiRead(ADDR_WATCHDOG_CTRL, rd);
        checkVal(rd, 32'hE, "control after pin reset");
        foreach (CLKW[i]) begin
            axiWrite(ADDR_SYSTEM_CTRL, {29'h0, CLKW[i]});
            expectPulse(CLKR[i] ? MALF_PULSE_CYC : 0);
            axiRead(ADDR_SYSTEM_CTRL, rd);
            checkVal(rd, CLKR[i] ? 32'h4 : {29'h0, CLKW[i]}, "clock control");
            checkVal({29'h0, highEn, lowEn, selLow}, rd, "oscillator outputs");
        end
        give_verdict();
    end
endmodule
